/* File: include/mx_pkg.sv */
`default_nettype none
package mx_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map of the bus slave.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_ACC = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_PC = 8'h0C;
  localparam logic [7:0] ADR_STATE = 8'h10;
  localparam int CTRL_RUN_BIT = 0;
  localparam int FLAGS_W = 6;
  localparam int PC_W = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [10:0] PC_RST = 11'h000;
  localparam logic [1:0] PHASE_RST = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Data memory byte whose writes also load the low program counter byte.
  localparam logic [6:0] PCL_ADDR = 7'h02;
  // Last system clock of one four-clock instruction cycle.
  localparam logic [1:0] PHASE_LAST = 2'h3;
  // Decimal adjust limits.
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_EXTRA = 4'b0100,
    ST_HALT = 4'b1000
  } mx_state_t;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_INVERT_TO_WORKING = 4'h1,
    OP_DECIMAL_ADJUST = 4'h2,
    OP_DEC = 4'h3,
    OP_DECREMENT_TO_WORKING = 4'h4,
    OP_INC = 4'h5,
    OP_INCREMENT_TO_WORKING = 4'h6,
    OP_HALT = 4'h7,
    OP_JUMP = 4'h8,
    OP_MOVE_MEM_TO_W = 4'h9,
    OP_MOVE_IMM_TO_W = 4'hA,
    OP_MOVE_W_TO_MEM = 4'hB,
    OP_OR_MEM_TO_W = 4'hC,
    OP_OR_IMM_TO_W = 4'hD,
    OP_OR_INTO_MEMORY = 4'hE
  } mx_op_t;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic timeout_flag;
    logic power_down_flag;
    logic overflow_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } mx_flags_t;

  localparam mx_flags_t FLAGS_RST = 6'h00;

  typedef struct packed {
    mx_op_t op;
    logic [6:0] addr;
    logic [7:0] imm;
    logic [10:0] jump_addr;
  } mx_instr_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
  } mx_mem_req_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mx_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } mx_wb_rsp_t;

endpackage
`default_nettype wire

/* File: rtl/mx_phase.sv */
`timescale 1ns/1ps
`default_nettype none
// Marks the last of the four system clocks of an instruction cycle.
module mx_phase
  import mx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic clear,
  output var logic tick
);

  typedef struct packed {
    logic [1:0] count;
  } mx_phase_st_t;

  mx_phase_st_t q;
  mx_phase_st_t next_q;

  always_comb begin
    next_q = q;
    if (clear) begin
      next_q.count = PHASE_RST;
    end else begin
      next_q.count = q.count + 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= '{count: PHASE_RST};
    end else begin
      q <= next_q;
    end
  end

  assign tick = (q.count == PHASE_LAST);

endmodule
`default_nettype wire

/* File: rtl/mx_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module mx_alu
  import mx_pkg::*;
(
  // Operands
  input wire mx_op_t op,
  input wire logic [7:0] acc,
  input wire logic [7:0] mem,
  input wire logic [7:0] imm,
  input wire logic c_in,
  input wire logic ac_in,
  // Result and write steering
  output var logic [7:0] res,
  output var logic wr_acc,
  output var logic wr_mem,
  output var logic upd_z,
  output var logic upd_c,
  output var logic c_out
);

  function automatic logic [8:0] decimal_adjust(input logic [7:0] a,
                                                input logic ac,
                                                input logic c);
    logic [3:0] lo;
    logic nibble_carry_internal;
    logic [4:0] hi;
    logic c_n;
    if (a[3:0] > BCD_MAX || ac) begin
      lo = a[3:0] + BCD_FIX;
      nibble_carry_internal = !ac;
    end else begin
      lo = a[3:0];
      nibble_carry_internal = 1'b0;
    end
    hi = {1'b0, a[7:4]} + {4'h0, nibble_carry_internal};
    if (hi > {1'b0, BCD_MAX} || c) begin
      hi = hi + {1'b0, BCD_FIX};
      c_n = 1'b1;
    end else begin
      c_n = c;
    end
    return {c_n, hi[3:0], lo};
  endfunction

  always_comb begin
    res = 8'h00;
    wr_acc = 1'b0;
    wr_mem = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    c_out = c_in;
    unique case (op)
      OP_NOP, OP_HALT, OP_JUMP: begin
      end
      OP_INVERT_TO_WORKING: begin
        res = ~mem;
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      OP_DECIMAL_ADJUST: begin
        {c_out, res} = decimal_adjust(acc, ac_in, c_in);
        wr_mem = 1'b1;
        upd_c = 1'b1;
      end
      OP_DEC: begin
        res = mem - 8'h01;
        wr_mem = 1'b1;
        upd_z = 1'b1;
      end
      OP_DECREMENT_TO_WORKING: begin
        res = mem - 8'h01;
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      OP_INC, OP_INCREMENT_TO_WORKING: begin
        res = mem + 8'h01;
        wr_mem = (op == OP_INC);
        wr_acc = (op == OP_INCREMENT_TO_WORKING);
        upd_z = 1'b1;
      end
      OP_MOVE_MEM_TO_W: begin
        res = mem;
        wr_acc = 1'b1;
      end
      OP_MOVE_IMM_TO_W: begin
        res = imm;
        wr_acc = 1'b1;
      end
      OP_MOVE_W_TO_MEM: begin
        res = acc;
        wr_mem = 1'b1;
      end
      OP_OR_MEM_TO_W: begin
        res = acc | mem;
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      OP_OR_IMM_TO_W: begin
        res = acc | imm;
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      OP_OR_INTO_MEMORY: begin
        res = acc | mem;
        wr_mem = 1'b1;
        upd_z = 1'b1;
      end
      default: begin
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: rtl/mx_exec_top.sv */
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Invert-to-working puts the inverted memory byte in W, memory untouched.
// - Low nibble above 9 or half carry: add 6, nibble carry is not half carry.
// - High nibble plus nibble carry above 9 or carry: add 6, set carry.
// - Decimal adjust writes memory, and only carry may change.
// - Decrement writes memory byte minus one back to that byte.
// - Decrement-to-working puts memory minus one in W, memory untouched.
// - Increment writes memory plus one; its working form writes W instead.
// - Halt stops execution and clock, keeps contents, advances counter by one.
// - Halt clears the watchdog counter and its prescaler.
// - Halt sets power-down and clears time-out.
// - Jump loads the program counter with the instruction address.
// - Move from memory copies the memory byte into W.
// - Move immediate loads the 8-bit constant into W.
// - Move to memory copies W into the memory byte.
// - No-operation only advances the program counter by one.
// - Or with memory puts W or memory into W.
// - Or immediate puts W or the constant into W.
// - Invert, increment, decrement and or update zero only.
// - Moves, jump and no-operation change no flag.
// - A memory write to the counter low byte adds one four-clock cycle.
module mx_exec_top
  import mx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register bus
  input wire mx_wb_req_t wb_req,
  output var mx_wb_rsp_t wb_rsp,
  // Instruction from fetch
  input wire logic ins_valid,
  input wire mx_instr_t ins,
  output var logic ins_ready,
  output var logic ins_done,
  output var logic [10:0] program_counter,
  // Data memory
  output var mx_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  // Power and watchdog
  input wire logic wake_req,
  input wire logic timeout_evt,
  output var logic sys_clk_run,
  output var logic wdt_clear,
  // Visible state
  output var logic [7:0] working_reg,
  output var mx_flags_t status_flags
);

  typedef struct packed {
    mx_state_t st;
    logic ready;
    logic done;
    logic [10:0] pc;
    logic [7:0] acc;
    mx_flags_t fl;
    mx_instr_t ins;
    mx_mem_req_t mem;
    logic clk_run;
    logic wdt_clr;
    logic run_en;
    logic ack;
    logic [31:0] rdat;
  } mx_exec_st_t;

  localparam mx_exec_st_t Q_RST = '{
    st: ST_IDLE, ready: 1'b1, done: 1'b0, pc: PC_RST, acc: ACC_RST,
    fl: FLAGS_RST, ins: '0, mem: '0, clk_run: 1'b1, wdt_clr: 1'b0,
    run_en: CTRL_RUN_RST, ack: 1'b0, rdat: 32'h0000_0000
  };

  mx_exec_st_t q;
  mx_exec_st_t next_q;

  logic bus_hit;
  logic accept;
  logic tick;
  logic commit;
  logic [7:0] alu_res;
  logic alu_wr_acc;
  logic alu_wr_mem;
  logic alu_upd_z;
  logic alu_upd_c;
  logic alu_c;

  function automatic logic [31:0] reg_read(input logic [7:0] adr,
                                           input mx_exec_st_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (adr)
      ADR_CTRL: d[CTRL_RUN_BIT] = s.run_en;
      ADR_ACC: d[7:0] = s.acc;
      ADR_STATUS: d[FLAGS_W-1:0] = s.fl;
      ADR_PC: d[PC_W-1:0] = s.pc;
      ADR_STATE: d[3:0] = s.st;
      default: d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle timing and the operation datapath.
  assign bus_hit = wb_req.cyc && wb_req.stb;
  assign accept = (q.st == ST_IDLE) && q.ready && q.run_en && ins_valid;
  assign commit = (q.st == ST_EXEC) && tick;

  mx_phase u_phase (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(accept),
    .tick(tick)
  );

  mx_alu u_alu (
    .op(q.ins.op),
    .acc(q.acc),
    .mem(mem_rdata),
    .imm(q.ins.imm),
    .c_in(q.fl.carry),
    .ac_in(q.fl.half_carry_flag),
    .res(alu_res),
    .wr_acc(alu_wr_acc),
    .wr_mem(alu_wr_mem),
    .upd_z(alu_upd_z),
    .upd_c(alu_upd_c),
    .c_out(alu_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic extra;
    extra = 1'b0;
    next_q = q;
    next_q.done = 1'b0;
    next_q.wdt_clr = 1'b0;
    next_q.mem.we = 1'b0;
    next_q.ack = bus_hit && !q.ack;
    if (bus_hit && !q.ack) begin
      next_q.rdat = reg_read(wb_req.adr, q);
    end
    // A write lands on the edge where the master sees ack, so it never
    // repeats. An instruction committing on that edge overrides the fields it writes.
    if (bus_hit && q.ack && wb_req.we && wb_req.sel[0]) begin
      case (wb_req.adr)
        ADR_CTRL: next_q.run_en = wb_req.dat[CTRL_RUN_BIT];
        ADR_ACC: next_q.acc = wb_req.dat[7:0];
        ADR_STATUS: next_q.fl = wb_req.dat[FLAGS_W-1:0];
        default: begin
        end
      endcase
    end
    unique case (q.st)
      ST_IDLE: begin
        if (accept) begin
          next_q.ins = ins;
          next_q.mem.addr = ins.addr;
          next_q.ready = 1'b0;
          next_q.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (tick) begin
          next_q.pc = q.pc + 11'h001;
          if (alu_wr_acc) begin
            next_q.acc = alu_res;
          end
          if (alu_wr_mem) begin
            next_q.mem.we = 1'b1;
            next_q.mem.wdata = alu_res;
          end
          if (alu_upd_z) begin
            next_q.fl.zero = (alu_res == 8'h00);
          end
          if (alu_upd_c) begin
            next_q.fl.carry = alu_c;
          end
          if (alu_wr_mem && q.ins.addr == PCL_ADDR) begin
            next_q.pc = {q.pc[10:8], alu_res};
            extra = 1'b1;
          end
          if (q.ins.op == OP_JUMP) begin
            next_q.pc = q.ins.jump_addr;
            extra = 1'b1;
          end
          if (q.ins.op == OP_HALT) begin
            next_q.fl.power_down_flag = 1'b1;
            next_q.fl.timeout_flag = 1'b0;
            next_q.wdt_clr = 1'b1;
            next_q.clk_run = 1'b0;
            next_q.st = ST_HALT;
          end else if (extra) begin
            next_q.st = ST_EXTRA;
          end else begin
            next_q.st = ST_IDLE;
            next_q.ready = 1'b1;
            next_q.done = 1'b1;
          end
        end
      end
      ST_EXTRA: begin
        if (tick) begin
          next_q.st = ST_IDLE;
          next_q.ready = 1'b1;
          next_q.done = 1'b1;
        end
      end
      ST_HALT: begin
        if (wake_req) begin
          next_q.clk_run = 1'b1;
          next_q.st = ST_IDLE;
          next_q.ready = 1'b1;
          next_q.done = 1'b1;
        end
      end
      default: begin
        next_q.st = ST_IDLE;
        next_q.ready = 1'b1;
      end
    endcase
    // A watchdog time-out in the same cycle as a clear still sets the flag.
    if (timeout_evt) begin
      next_q.fl.timeout_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q <= Q_RST;
    end else begin
      q <= next_q;
    end
  end

  assign wb_rsp = '{ack: q.ack, dat: q.rdat};
  assign ins_ready = q.ready;
  assign ins_done = q.done;
  assign program_counter = q.pc;
  assign mem_req = q.mem;
  assign sys_clk_run = q.clk_run;
  assign wdt_clear = q.wdt_clr;
  assign working_reg = q.acc;
  assign status_flags = q.fl;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the committed results.
  property p_invert;
    @(posedge clk_sys) disable iff (!resetn)
    commit && q.ins.op == OP_INVERT_TO_WORKING |=>
      q.acc == ~$past(mem_rdata) && !q.mem.we;
  endproperty
  a_invert: assert property (p_invert)
    else $error("inverted byte not in working register");

  property p_dec;
    @(posedge clk_sys) disable iff (!resetn)
    commit && q.ins.op == OP_DEC |=>
      q.mem.we && q.mem.wdata == $past(mem_rdata) - 8'h01;
  endproperty
  a_dec: assert property (p_dec)
    else $error("decrement not written back");

  property p_move_out;
    @(posedge clk_sys) disable iff (!resetn)
    commit && q.ins.op == OP_MOVE_W_TO_MEM && !timeout_evt |=>
      q.mem.we && q.mem.wdata == $past(q.acc) && q.fl == $past(q.fl);
  endproperty
  a_move_out: assert property (p_move_out)
    else $error("move to memory wrong");

  property p_halt_flags;
    @(posedge clk_sys) disable iff (!resetn)
    commit && q.ins.op == OP_HALT && !timeout_evt |=>
      q.fl.power_down_flag && !q.fl.timeout_flag && q.wdt_clr;
  endproperty
  a_halt_flags: assert property (p_halt_flags)
    else $error("halt flags wrong");

  property p_halt_stop;
    @(posedge clk_sys) disable iff (!resetn)
    commit && q.ins.op == OP_HALT && !wake_req |=>
      !q.clk_run ##1 (!q.ready && q.pc == $past(q.pc, 2) + 11'h001);
  endproperty
  a_halt_stop: assert property (p_halt_stop)
    else $error("halt did not stop");

  property p_wake;
    @(posedge clk_sys) disable iff (!resetn)
    q.st == ST_HALT && wake_req |=> q.clk_run && q.ready;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake did not restart");

  property p_jump;
    @(posedge clk_sys) disable iff (!resetn)
    commit && q.ins.op == OP_JUMP |=> q.pc == $past(q.ins.jump_addr);
  endproperty
  a_jump: assert property (p_jump)
    else $error("jump target not loaded");

  property p_pcl_extra;
    @(posedge clk_sys) disable iff (!resetn)
    commit && alu_wr_mem && q.ins.addr == PCL_ADDR |=>
      (q.st == ST_EXTRA) [*4] ##1 (q.st == ST_IDLE && q.done);
  endproperty
  a_pcl_extra: assert property (p_pcl_extra)
    else $error("extra cycle length wrong");

  property p_nop;
    @(posedge clk_sys) disable iff (!resetn)
    commit && q.ins.op == OP_NOP |=>
      q.pc == $past(q.pc) + 11'h001 && !q.mem.we;
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-operation changed state");

endmodule
`default_nettype wire

/* File: verif/mx_data_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Data memory behind the execute block: synchronous read with one clock
// of latency, and a write on each request pulse.
module mx_data_mem_model
  import mx_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Memory request and read data
  input wire mx_mem_req_t mem_req,
  output var logic [7:0] mem_rdata
);
  logic [7:0] mem [0:127];

  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'h00;
    end
  end

  // A plain always block, so the bench may preload bytes directly.
  always @(posedge clk_sys) begin
    mem_rdata <= mem[mem_req.addr];
    if (mem_req.we === 1'b1) begin
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule
`default_nettype wire

/* File: verif/mx_exec_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module mx_exec_top_bench
  import mx_pkg::*;
;
  localparam logic [6:0] OPA = 7'h20;
  logic clk_sys, resetn, ins_valid, ins_ready, ins_done;
  logic wake_req, timeout_evt, sys_clk_run, wdt_clear;
  logic [7:0] mem_rdata, working_reg;
  logic [10:0] program_counter, pc0;
  logic [31:0] rd;
  mx_wb_req_t wb_req;
  mx_wb_rsp_t wb_rsp;
  mx_instr_t ins;
  mx_mem_req_t mem_req;
  mx_flags_t status_flags;
  int mismatches, check_count, cycles, wdt_seen, n;

  mx_exec_top uut (.clk_sys(clk_sys), .resetn(resetn), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .ins_valid(ins_valid), .ins(ins),
    .ins_ready(ins_ready), .ins_done(ins_done),
    .program_counter(program_counter), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .wake_req(wake_req), .timeout_evt(timeout_evt),
    .sys_clk_run(sys_clk_run), .wdt_clear(wdt_clear),
    .working_reg(working_reg), .status_flags(status_flags));
  mx_data_mem_model data_mem (.clk_sys(clk_sys), .mem_req(mem_req),
    .mem_rdata(mem_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (wdt_clear === 1'b1) wdt_seen++;
    if (cycles == 5000) begin
      mismatches++;
      $display("timeout reached");
      report_and_stop();
    end
  end

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Values are sampled at the edge before that edge's updates land.
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clk_sys);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, wd};
    do @(posedge clk_sys); while (wb_rsp.ack !== 1'b1);
    rdat = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic wb_rd_check(input string name, input logic [7:0] adr,
                             input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000, rd);
    check(name, exp, rd);
  endtask

  // Returns the edges from take to the sampled done, or 0 if none came.
  task automatic exec(input mx_op_t op, input logic [6:0] a,
                      input logic [7:0] imm, input logic [10:0] ja,
                      input int limit, output int cnt);
    @(posedge clk_sys);
    ins_valid <= 1'b1;
    ins <= '{op, a, imm, ja};
    do @(posedge clk_sys); while (ins_ready !== 1'b1);
    ins_valid <= 1'b0;
    cnt = 0;
    do begin
      @(posedge clk_sys);
      cnt++;
    end while (ins_done !== 1'b1 && cnt < limit);
    if (ins_done !== 1'b1) cnt = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [21:0] predict(input mx_op_t op,
    input logic [7:0] a, input logic [7:0] m, input logic [7:0] imm,
    input mx_flags_t f);
    logic [3:0] lo;
    logic [4:0] hi;
    logic k;
    case (op)
      OP_INVERT_TO_WORKING: a = ~m;
      OP_DECIMAL_ADJUST: begin
        k = 1'b0;
        lo = a[3:0];
        if (a[3:0] > BCD_MAX || f.half_carry_flag) begin
          lo = a[3:0] + BCD_FIX;
          k = ~f.half_carry_flag;
        end
        hi = {1'b0, a[7:4]} + {4'h0, k};
        if (hi > {1'b0, BCD_MAX} || f.carry) begin
          hi = hi + {1'b0, BCD_FIX};
          f.carry = 1'b1;
        end
        m = {hi[3:0], lo};
      end
      OP_DEC: m = m - 8'h01;
      OP_DECREMENT_TO_WORKING: a = m - 8'h01;
      OP_INC: m = m + 8'h01;
      OP_INCREMENT_TO_WORKING: a = m + 8'h01;
      OP_MOVE_MEM_TO_W: a = m;
      OP_MOVE_IMM_TO_W: a = imm;
      OP_MOVE_W_TO_MEM: m = a;
      OP_OR_MEM_TO_W: a = a | m;
      OP_OR_IMM_TO_W: a = a | imm;
      OP_OR_INTO_MEMORY: m = a | m;
      default: ;
    endcase
    if (op inside {OP_INVERT_TO_WORKING, OP_DECREMENT_TO_WORKING,
        OP_INCREMENT_TO_WORKING, OP_OR_MEM_TO_W, OP_OR_IMM_TO_W}) begin
      f.zero = (a == 8'h00);
    end
    if (op inside {OP_DEC, OP_INC, OP_OR_INTO_MEMORY}) begin
      f.zero = (m == 8'h00);
    end
    return {a, m, f};
  endfunction

  task automatic run_op(input mx_op_t op, input logic [6:0] a,
    input logic [7:0] m, input logic [7:0] acc, input logic [7:0] imm,
    input logic [5:0] f, input logic [10:0] ja);
    logic [21:0] e;
    logic [10:0] epc;
    int lat;
    int cnt;
    e = predict(op, acc, m, imm, f);
    epc = program_counter + 11'h001;
    lat = 5;
    if (op == OP_JUMP) begin
      epc = ja;
      lat = 9;
    end else if (a == PCL_ADDR) begin
      epc = {program_counter[10:8], e[13:6]};
      lat = 9;
    end
    data_mem.mem[a] = m;
    wb_xfer(1'b1, ADR_ACC, {24'h0, acc}, rd);
    wb_xfer(1'b1, ADR_STATUS, {26'h0, f}, rd);
    exec(op, a, imm, ja, 12, cnt);
    @(posedge clk_sys);
    check("latency", lat, cnt);
    check("working", e[21:14], working_reg);
    check("memory", e[13:6], data_mem.mem[a]);
    check("flags", e[5:0], status_flags);
    check("counter", epc, program_counter);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    wb_req = '0;
    ins_valid = 1'b0;
    ins = '0;
    wake_req = 1'b0;
    timeout_evt = 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    wb_rd_check("ctrl", ADR_CTRL, 32'h0000_0001);
    wb_rd_check("state", ADR_STATE, 32'h0000_0001);
    wb_rd_check("status", ADR_STATUS, 32'h0000_0000);
    wb_rd_check("unmapped", 8'h14, 32'h0000_0000);
    wb_xfer(1'b1, ADR_PC, 32'h0000_0123, rd);
    wb_rd_check("pc read only", ADR_PC, 32'h0000_0000);
    $display("test reset done");
    run_op(OP_INVERT_TO_WORKING, OPA, 8'hFF, 8'h12, 8'h00, 6'h03,
           11'h000);
    run_op(OP_DECIMAL_ADJUST, OPA, 8'h55, 8'h9A, 8'h00, 6'h00,
           11'h000);
    run_op(OP_DECIMAL_ADJUST, OPA, 8'h00, 8'h3F, 8'h00, 6'h02,
           11'h000);
    run_op(OP_DECIMAL_ADJUST, OPA, 8'h00, 8'h99, 8'h00, 6'h01,
           11'h000);
    run_op(OP_DECIMAL_ADJUST, OPA, 8'h77, 8'h15, 8'h00, 6'h06,
           11'h000);
    run_op(OP_DEC, OPA, 8'h00, 8'h33, 8'h00, 6'h04, 11'h000);
    run_op(OP_DECREMENT_TO_WORKING, OPA, 8'h01, 8'h33, 8'h00, 6'h00,
           11'h000);
    run_op(OP_INC, OPA, 8'hFF, 8'h33, 8'h00, 6'h0B, 11'h000);
    run_op(OP_INCREMENT_TO_WORKING, OPA, 8'h7F, 8'h00, 8'h00, 6'h00,
           11'h000);
    run_op(OP_MOVE_MEM_TO_W, OPA, 8'h00, 8'h44, 8'h00, 6'h0B,
           11'h000);
    run_op(OP_MOVE_IMM_TO_W, OPA, 8'h11, 8'h00, 8'h3C, 6'h04,
           11'h000);
    run_op(OP_MOVE_W_TO_MEM, OPA, 8'h11, 8'hA5, 8'h00, 6'h0F,
           11'h000);
    run_op(OP_OR_MEM_TO_W, OPA, 8'h00, 8'h00, 8'hFF, 6'h03,
           11'h000);
    run_op(OP_OR_IMM_TO_W, OPA, 8'h0F, 8'h50, 8'h0A, 6'h04,
           11'h000);
    run_op(OP_OR_INTO_MEMORY, OPA, 8'hF0, 8'h0F, 8'h00, 6'h04,
           11'h000);
    run_op(OP_NOP, OPA, 8'h66, 8'h55, 8'hAA, 6'h0F, 11'h000);
    run_op(OP_JUMP, OPA, 8'h66, 8'h55, 8'h00, 6'h0B, 11'h5A3);
    run_op(OP_MOVE_W_TO_MEM, PCL_ADDR, 8'h00, 8'h40, 8'h00, 6'h00,
           11'h000);
    $display("test operations done");
    wb_xfer(1'b1, ADR_CTRL, 32'h0000_0000, rd);
    pc0 = program_counter;
    @(posedge clk_sys);
    ins_valid <= 1'b1;
    ins <= '{OP_NOP, OPA, 8'h00, 11'h000};
    repeat (8) @(posedge clk_sys);
    check("held counter", pc0, program_counter);
    wb_xfer(1'b1, ADR_CTRL, 32'h0000_0001, rd);
    @(posedge clk_sys);
    ins_valid <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check("run counter", pc0 + 11'h001, program_counter);
    $display("test run enable done");
    wb_xfer(1'b1, ADR_STATUS, 32'h0000_0020, rd);
    wb_xfer(1'b1, ADR_ACC, 32'h0000_0077, rd);
    pc0 = program_counter;
    wdt_seen = 0;
    exec(OP_HALT, OPA, 8'h00, 11'h000, 12, n);
    check("halt done", 0, n);
    check("clock run", 0, sys_clk_run);
    check("halt counter", pc0 + 11'h001, program_counter);
    check("halt working", 8'h77, working_reg);
    check("watchdog clear", 1, wdt_seen);
    check("halt flags", 6'h10, status_flags);
    wb_rd_check("halt state", ADR_STATE, 32'h0000_0008);
    @(posedge clk_sys);
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    n = 0;
    while (ins_done !== 1'b1 && n < 4) begin
      @(posedge clk_sys);
      n++;
    end
    check("wake done", 1, ins_done);
    check("clock back", 1, sys_clk_run);
    @(posedge clk_sys);
    timeout_evt <= 1'b1;
    @(posedge clk_sys);
    timeout_evt <= 1'b0;
    @(posedge clk_sys);
    check("timeout flag", 1, status_flags.timeout_flag);
    $display("test halt done");
    report_and_stop();
  end
endmodule
`default_nettype wire
